// ===== dv/spc_config_port_bench.sv
// Self-checking bench for the configuration port
`timescale 1ns/1ps
`default_nettype none
module spc_config_port_bench;
   import spc_pkg::*;
   typedef struct packed {logic [7:0] d; logic cs_n; logic we_n; logic take;} spc_row_type;
   logic         clk_in = 1'h0, rst_b_in = 1'h0, crc = 1'h0, fin = 1'h0, rdy = 1'h1, pers = 1'h0;
   logic [2:0]   mode = MODE_SLAVE_PAR;
   logic         prog_n, config_clock, cs_n, we_n, init_pin, busy, init_o, init_oe, done_o, done_oe;
   logic         high_while_loading, chain, user_io, rdbk;
   logic [2:0]   ldc, mode_s;
   logic [7:0]   data;
   spc_byte_type sink;
   logic [7:0]   exp_q[$];
   int           n_fail = 0, samples_checked = 0;
   spc_row_type  rows[5] = '{'{8'hA5, 1'h0, 1'h0, 1'h1}, '{8'h5A, 1'h0, 1'h0, 1'h1},
      '{8'h00, 1'h1, 1'h0, 1'h0}, '{8'hFF, 1'h0, 1'h1, 1'h0}, '{8'h3C, 1'h0, 1'h0, 1'h1}};
   always #2 clk_in = ~clk_in;
   // Open-drain init wire with its pull-up
   assign init_pin = init_oe ? init_o : 1'h1;
   spc_host_model i_spc_host_model (.clk_in(clk_in), .busy_in(busy), .prog_n_out(prog_n),
      .config_clock_out(config_clock), .cs_n_out(cs_n), .we_n_out(we_n), .data_out(data));
   spc_config_port #(.CLEAR_CYCLES(8)) i_spc_config_port (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .program_restart_n_in(prog_n), .config_clock_in(config_clock), .chip_select_n_in(cs_n),
      .write_enable_n_in(we_n), .data_in(data), .mode_select_in(mode), .init_pin_in(init_pin),
      .persist_in(pers), .crc_error_in(crc), .load_complete_in(fin), .sink_ready_in(rdy),
      .sink_out(sink), .busy_out(busy), .init_out(init_o), .init_oe_out(init_oe), .done_out(done_o),
      .done_oe_out(done_oe), .low_while_loading_out(ldc), .high_while_loading_out(high_while_loading),
      .chain_select_out_n_out(chain), .mode_sampled_out(mode_s), .user_io_out(user_io),
      .readback_out(rdbk));
   task automatic chk(input logic c, input string m);
      samples_checked++;
      if (c !== 1'h1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // Sampled mid-cycle: the pop at the next rising edge sees these same values
   always @(negedge clk_in) begin
      if (sink.valid === 1'h1 && rdy === 1'h1) begin
         chk(exp_q.size() > 0 && sink.data === exp_q[0], "byte order");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   task automatic wait_init;
      int w;
      w = 0;
      while (init_pin !== 1'h1 && w < 400) begin
         @(posedge clk_in);
         w++;
      end
      repeat (8) @(posedge clk_in);
      #1;
      chk(w < 400 && mode_s === mode, "init release");
   endtask : wait_init
   task automatic strobe(input logic crc_sel);
      @(posedge clk_in) #1 crc = crc_sel;
      fin = !crc_sel;
      @(posedge clk_in) #1 crc = 1'h0;
      fin = 1'h0;
      repeat (2) @(posedge clk_in);
   endtask : strobe
   task automatic send(input logic [7:0] d);
      exp_q.push_back(d);
      i_spc_host_model.put(d, 1'h0, 1'h0);
   endtask : send
   initial begin
      repeat (6) @(posedge clk_in);
      #1 rst_b_in = 1'h1;
      chk(init_oe === 1'h1 && done_oe === 1'h1, "reset indicators");
      chk(ldc === LOW_LOADING && high_while_loading === 1'h1 && chain === 1'h1, "reset side pins");
      i_spc_host_model.pulse_program(90);
      chk(init_pin === 1'h0, "init low while clearing");
      wait_init();
      foreach (rows[i]) begin
         if (rows[i].take) exp_q.push_back(rows[i].d);
         i_spc_host_model.put(rows[i].d, rows[i].cs_n, rows[i].we_n);
      end
      @(posedge clk_in) #1 rdy = 1'h0;
      send(8'h11);
      send(8'h22);
      repeat (8) @(posedge clk_in);
      chk(busy === 1'h1 && sink.valid === 1'h1 && sink.data === 8'h11, "stall holds");
      #1 rdy = 1'h1;
      send(8'h33);
      repeat (20) @(posedge clk_in);
      chk(exp_q.size() == 0, "all bytes out");
      strobe(1'h0);
      chk(done_oe === 1'h0 && ldc === LOW_RELEASED && high_while_loading === 1'h0 && chain === 1'h0, "done");
      chk(user_io === 1'h1 && rdbk === 1'h0, "user pins");
      i_spc_host_model.pulse_program(30);
      repeat (10) @(posedge clk_in);
      chk(done_oe === 1'h0, "short pulse ignored");
      i_spc_host_model.pulse_program(90);
      chk(done_oe === 1'h1 && init_pin === 1'h0, "restart");
      wait_init();
      send(8'h5C);
      repeat (20) @(posedge clk_in);
      strobe(1'h1);
      chk(init_pin === 1'h0 && done_oe === 1'h1, "crc failure");
      i_spc_host_model.pulse_program(90);
      wait_init();
      pers = 1'h1;
      strobe(1'h0);
      chk(rdbk === 1'h1 && user_io === 1'h0, "persist readback");
      @(posedge clk_in) #1 mode = 3'h7;
      i_spc_host_model.pulse_program(90);
      wait_init();
      i_spc_host_model.put(8'h77, 1'h0, 1'h0);
      repeat (10) @(posedge clk_in);
      chk(sink.valid === 1'h0 && done_oe === 1'h1 && init_pin === 1'h1, "other mode ignores data");
      end_sim();
   end
   initial begin
      #40000;
      n_fail++;
      end_sim();
   end
endmodule : spc_config_port_bench
`default_nettype wire

// ===== dv/spc_config_port_monitor.sv
// Port checker for the configuration port
`timescale 1ns/1ps
`default_nettype none
module spc_config_port_monitor
   import spc_pkg::*;
#(
   parameter int CLEAR_CYCLES = CLEAR_CYC_DEF
) (
   input wire logic                  clk_in,
   input wire logic                  rst_b_in,
   input wire logic                  program_restart_n_in,
   input wire logic                  crc_error_in,
   input wire logic                  load_complete_in,
   input wire logic                  sink_ready_in,
   input wire spc_pkg::spc_byte_type sink_out,
   input wire logic                  busy_out,
   input wire logic                  init_oe_out,
   input wire logic                  done_oe_out,
   input wire logic [2:0]            low_while_loading_out,
   input wire logic                  high_while_loading_out,
   input wire logic                  chain_select_out_n_out,
   input wire logic                  user_io_out,
   input wire logic                  readback_out
);
   // Margin covers the pin synchroniser ahead of the filter
   localparam int PROG_CHK = PROG_LOW_CYC + 8;
   int low_cnt_q;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt_q <= 0;
      end else begin
         low_cnt_q <= program_restart_n_in ? 0 : (low_cnt_q < 1000 ? low_cnt_q + 1 : low_cnt_q);
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   loading_low_a: assert property (done_oe_out |-> low_while_loading_out == LOW_LOADING)
      else $error("low pins not low while loading");
   loading_high_a: assert property (done_oe_out |-> high_while_loading_out)
      else $error("high pin not high while loading");
   chain_on_done_a: assert property (!done_oe_out |-> !chain_select_out_n_out)
      else $error("next device not selected");
   done_cause_a: assert property ($fell(done_oe_out) |-> $past(load_complete_in))
      else $error("done released without completion");
   prog_restart_a: assert property (low_cnt_q == PROG_CHK |-> init_oe_out && done_oe_out)
      else $error("long program low did not restart");
   init_hold_a: assert property ($fell(init_oe_out) |-> $past(program_restart_n_in, 3))
      else $error("init released under program low");
   byte_stands_a: assert property (sink_out.valid && !sink_ready_in && !init_oe_out && done_oe_out
      && !crc_error_in && !load_complete_in |=> sink_out.valid && $stable(sink_out.data))
      else $error("stalled byte lost");
   busy_full_a: assert property (busy_out |-> sink_out.valid)
      else $error("busy with empty buffer");
   persist_sel_a: assert property (user_io_out |-> !readback_out && !done_oe_out)
      else $error("pin role wrong");
endmodule : spc_config_port_monitor
bind spc_config_port spc_config_port_monitor #(.CLEAR_CYCLES(CLEAR_CYCLES)) i_spc_config_port_monitor (
   .clk_in, .rst_b_in, .program_restart_n_in, .crc_error_in, .load_complete_in, .sink_ready_in,
   .sink_out, .busy_out, .init_oe_out, .done_oe_out, .low_while_loading_out, .high_while_loading_out,
   .chain_select_out_n_out, .user_io_out, .readback_out);
`default_nettype wire

// ===== dv/spc_host_model.sv
// Host model driving the configuration pins
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
   input  wire logic       clk_in,
   input  wire logic       busy_in,
   output var  logic       prog_n_out = 1'h1,
   output var  logic       config_clock_out = 1'h0,
   output var  logic       cs_n_out = 1'h1,
   output var  logic       we_n_out = 1'h1,
   output var  logic [7:0] data_out = 8'h00
);
   task automatic pulse_program(input int cyc);
      @(posedge clk_in) #1 prog_n_out = 1'h0;
      repeat (cyc) @(posedge clk_in);
      #1 prog_n_out = 1'h1;
   endtask : pulse_program
   // Clock idles low between bytes; no free-running edges
   task automatic put(input logic [7:0] d, input logic cs_n, input logic we_n);
      int w;
      w = 0;
      while (busy_in === 1'h1 && w < 500) begin
         @(posedge clk_in);
         w++;
      end
      @(posedge clk_in) #1 data_out = d;
      cs_n_out = cs_n;
      we_n_out = we_n;
      #80 config_clock_out = 1'h1;
      #80 config_clock_out = 1'h0;
      // Released bus shows the inverse, never a stale byte
      data_out = ~d;
   endtask : put
endmodule : spc_host_model
`default_nettype wire

// ===== verilog/spc_config_port.sv
// Byte-wide slave configuration port, device side
`timescale 1ns/1ps
`default_nettype none
module spc_config_port
   import spc_pkg::*;
#(
   parameter int CLEAR_CYCLES = CLEAR_CYC_DEF
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  program_restart_n_in,
   input  wire logic                  config_clock_in,
   input  wire logic                  chip_select_n_in,
   input  wire logic                  write_enable_n_in,
   input  wire logic [7:0]            data_in,
   input  wire logic [2:0]            mode_select_in,
   input  wire logic                  init_pin_in,
   input  wire logic                  persist_in,
   input  wire logic                  crc_error_in,
   input  wire logic                  load_complete_in,
   input  wire logic                  sink_ready_in,
   output var  spc_pkg::spc_byte_type sink_out,
   output var  logic                  busy_out,
   output var  logic                  init_out,
   output var  logic                  init_oe_out,
   output var  logic                  done_out,
   output var  logic                  done_oe_out,
   output var  logic [2:0]            low_while_loading_out,
   output var  logic                  high_while_loading_out,
   output var  logic                  chain_select_out_n_out,
   output var  logic [2:0]            mode_sampled_out,
   output var  logic                  user_io_out,
   output var  logic                  readback_out
);
   import spc_pkg::*;

   localparam int CW = $clog2(CLEAR_CYCLES + 1);
   localparam int PW = $clog2(PROG_LOW_CYC + 1);

   // Buffer level decode, shared by push, pop and the output flags
   function automatic logic level_is(input logic [1:0] c, input logic [1:0] n);
      return (c == n);
   endfunction : level_is

   initial begin
      if (CLEAR_CYCLES < 1) begin
         $error("CLEAR_CYCLES must be at least 1");
      end
      if (PROG_LOW_CYC < 1) begin
         $error("program filter needs at least one cycle");
      end
      if (BUF_DEPTH != 2'h2) begin
         $error("buffer logic serves exactly two entries");
      end
   end

   // Pin synchroniser: three stages, a change counts once stages two and three agree
   spc_pins_type  pins_raw;
   spc_pins_type  s1_q;
   spc_pins_type  s2_q;
   spc_pins_type  s3_q;
   spc_pins_type  pf_q;
   spc_pins_type  pf_d;
   logic          config_clock_prev_q;

   // Data goes through the same stages as the clock so both line up at the edge
   assign pins_raw.prog_n = program_restart_n_in;
   assign pins_raw.config_clock   = config_clock_in;
   assign pins_raw.cs_n   = chip_select_n_in;
   assign pins_raw.we_n   = write_enable_n_in;
   assign pins_raw.init   = init_pin_in;
   assign pins_raw.mode   = mode_select_in;
   assign pins_raw.data   = data_in;
   assign pf_d = (s2_q & s3_q) | (pf_q & (s2_q ^ s3_q));

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_q        <= PINS_IDLE;
         s2_q        <= PINS_IDLE;
         s3_q        <= PINS_IDLE;
         pf_q        <= PINS_IDLE;
         config_clock_prev_q <= 1'b0;
      end else begin
         s1_q        <= pins_raw;
         s2_q        <= s1_q;
         s3_q        <= s2_q;
         pf_q        <= pf_d;
         config_clock_prev_q <= pf_q.config_clock;
      end
   end

   wire config_clock_rise = pf_q.config_clock & ~config_clock_prev_q;

   // Program pulse width; a glitch shorter than the minimum is ignored
   logic [PW-1:0] prog_cnt_q;
   logic [PW-1:0] prog_cnt_d;
   wire           prog_armed = (prog_cnt_q == PW'(PROG_LOW_CYC));

   assign prog_cnt_d = pf_q.prog_n ? '0 :
                       (prog_armed ? prog_cnt_q : prog_cnt_q + PW'(1));

   // Two-entry output buffer; slot 0 is the head so the byte leaves from a flop
   logic [1:0]    cnt_q;
   logic [1:0]    cnt_d;
   logic [7:0]    slot_q [2];
   logic [7:0]    slot0_d;
   logic [7:0]    slot1_d;
   logic          buf_full;
   logic          push;
   logic          pop;
   logic          flush;

   // Controller
   spc_state_type state_q;
   spc_state_type state_d;
   logic [CW-1:0] clear_cnt_q;
   logic [CW-1:0] clear_cnt_d;
   logic [2:0]    mode_q;
   logic [2:0]    mode_d;
   logic          persist_q;
   logic          persist_d;

   wire clear_end  = (clear_cnt_q == CW'(CLEAR_CYCLES - 1));
   wire selected   = ~pf_q.cs_n & ~pf_q.we_n;
   wire init_high  = pf_q.init;
   wire mode_match = (pf_q.mode == MODE_SLAVE_PAR);

   always_comb begin
      state_d     = state_q;
      clear_cnt_d = clear_cnt_q;
      mode_d      = mode_q;
      persist_d   = persist_q;
      case (state_q)
         ST_CLEAR: begin
            if (!pf_q.prog_n) begin
               clear_cnt_d = '0;
            end else if (clear_end) begin
               state_d = ST_WAIT_INIT;
            end else begin
               clear_cnt_d = clear_cnt_q + CW'(1);
            end
         end
         ST_WAIT_INIT: begin
            // Init is open-drain: another device may still hold it low
            if (init_high) begin
               mode_d  = pf_q.mode;
               state_d = mode_match ? ST_LOAD : ST_OTHER_MODE;
            end
         end
         ST_LOAD: begin
            if (crc_error_in) begin
               state_d = ST_ERROR;
            end else if (load_complete_in) begin
               state_d   = ST_DONE;
               persist_d = persist_in;
            end
         end
         ST_DONE: begin
            state_d = ST_DONE;
         end
         ST_ERROR: begin
            state_d = ST_ERROR;
         end
         ST_OTHER_MODE: begin
            state_d = ST_OTHER_MODE;
         end
         default: begin
            state_d = ST_CLEAR;
         end
      endcase
      // A long program pulse overrides every state and restarts clearing
      if (prog_armed) begin
         state_d     = ST_CLEAR;
         clear_cnt_d = '0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q     <= ST_CLEAR;
         clear_cnt_q <= '0;
         prog_cnt_q  <= '0;
         mode_q      <= 3'h0;
         persist_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         clear_cnt_q <= clear_cnt_d;
         prog_cnt_q  <= prog_cnt_d;
         mode_q      <= mode_d;
         persist_q   <= persist_d;
      end
   end

   // Buffer control; a byte offered while full is not taken and the host repeats it
   assign buf_full = level_is(cnt_q, BUF_DEPTH);
   assign flush    = (state_q != ST_LOAD);
   assign push     = (state_q == ST_LOAD) & config_clock_rise & selected & ~buf_full;
   assign pop      = ~level_is(cnt_q, 2'h0) & sink_ready_in;
   assign cnt_d    = flush ? 2'h0 : cnt_q + {1'b0, push} - {1'b0, pop};

   always_comb begin
      slot0_d = slot_q[0];
      slot1_d = slot_q[1];
      if (pop) begin
         slot0_d = (cnt_q == 2'h2) ? slot_q[1] : pf_q.data;
         if (push && (cnt_q == 2'h2)) begin
            slot1_d = pf_q.data;
         end
      end else if (push) begin
         if (cnt_q == 2'h0) begin
            slot0_d = pf_q.data;
         end else begin
            slot1_d = pf_q.data;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q     <= 2'h0;
         slot_q[0] <= 8'h00;
         slot_q[1] <= 8'h00;
      end else begin
         cnt_q     <= cnt_d;
         slot_q[0] <= slot0_d;
         slot_q[1] <= slot1_d;
      end
   end

   // Output flops, computed from next state except init_out and done_out, which are held at 0, so they track it without lag
   wire loading_d    = (state_d != ST_DONE);
   wire init_low_d   = (state_d == ST_CLEAR) | (state_d == ST_ERROR);
   wire sink_valid_d = ~level_is(cnt_d, 2'h0);
   // Busy only with both slots held; a rise while full is dropped and repeated by the host
   wire busy_d       = level_is(cnt_d, BUF_DEPTH);
   wire user_io_d    = ~loading_d & ~persist_d;
   wire readback_d   = ~loading_d & persist_d;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sink_out <= BYTE_IDLE;
         busy_out <= 1'b0;
      end else begin
         sink_out.valid <= sink_valid_d;
         sink_out.data  <= slot0_d;
         busy_out       <= busy_d;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         init_out               <= 1'b0;
         init_oe_out            <= 1'b1;
         done_out               <= 1'b0;
         done_oe_out            <= 1'b1;
         low_while_loading_out  <= LOW_LOADING;
         high_while_loading_out <= 1'b1;
         chain_select_out_n_out <= 1'b1;
         mode_sampled_out       <= 3'h0;
         user_io_out            <= 1'b0;
         readback_out           <= 1'b0;
      end else begin
         init_out               <= 1'b0;
         init_oe_out            <= init_low_d;
         done_out               <= 1'b0;
         done_oe_out            <= loading_d;
         low_while_loading_out  <= loading_d ? LOW_LOADING : LOW_RELEASED;
         high_while_loading_out <= loading_d;
         chain_select_out_n_out <= loading_d;
         mode_sampled_out       <= mode_d;
         user_io_out            <= user_io_d;
         readback_out           <= readback_d;
      end
   end
endmodule : spc_config_port
`default_nettype wire

// ===== verilog/spc_pkg.sv
// Constants, carriers and states of the byte-wide slave configuration port
package spc_pkg;
   localparam int          CLK_MHZ        = 250;
   localparam int          PROG_LOW_NS    = 300;
   // Least time, so rounded up to whole cycles
   localparam int          PROG_LOW_CYC   = (PROG_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int          CLEAR_CYC_DEF  = 1024;
   localparam logic [2:0]  MODE_SLAVE_PAR = 3'h6;
   localparam logic [1:0]  BUF_DEPTH      = 2'h2;
   localparam logic [2:0]  LOW_LOADING    = 3'h0;
   localparam logic [2:0]  LOW_RELEASED   = 3'h7;

   typedef struct packed {
      logic       prog_n;
      logic       config_clock;
      logic       cs_n;
      logic       we_n;
      logic       init;
      logic [2:0] mode;
      logic [7:0] data;
   } spc_pins_type;

   // Pins at rest: program high, deselected, init pulled up
   localparam logic [15:0] PINS_IDLE = 16'hB800;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } spc_byte_type;

   localparam logic [8:0]  BYTE_IDLE = 9'h000;

   typedef enum logic [2:0] {
      ST_CLEAR,
      ST_WAIT_INIT,
      ST_LOAD,
      ST_DONE,
      ST_ERROR,
      ST_OTHER_MODE
   } spc_state_type;
endpackage : spc_pkg
